// File: hw/wmg_pkg.sv
// Constants, carriers and states shared by the waveform marker generator.
// Assumes one 100 MHz clock and a 32-bit Avalon-MM register slave.
// Summary of operation
// R1: Each channel drives two marker outputs, kept in step with its sample stream.
// R2: Marker bits live in waveform memory beside each full-width sample word.
// R3: Marker start counts sample points from waveform start, in steps of four.
// R4: Start position and fine delay are separate settings; neither alters the other.
// R5: Marker width counts sample points, at least four, in steps of four.
// R6: A setting whose start plus width passes the waveform end is rejected.
// R7: Fine delay per marker spans zero to three nanoseconds in ten picosecond steps.
// R8: One channel enable switches both markers on and off together.
// R9: Local settings give one marker pulse referenced to the waveform start.
// R10: Remotely loaded marker bits play as arbitrary strings, one bit per sample.
// R11: Changed marker settings do nothing until an apply command arrives.
// R12: Apply reads memory, clears old marker bits and writes the new pattern.
// R13: Latency from waveform start to marker output is a fixed constant.
// R14: The apply cycle changes marker bits only, never the stored samples.
package wmg_pkg;

   localparam int WMG_SMP_W = 16;
   localparam int WMG_NMK = 2;
   localparam int WMG_AW = 12;
   localparam int WMG_LW = WMG_AW + 1;
   localparam int WMG_DW = 9;
   localparam int WMG_FIFO_D = 16;
   localparam int WMG_DATA_W = 32;
   localparam int WMG_BE_W = 4;
   localparam int WMG_BUS_AW = 6;

   // ----------------------------------------------------------------
   // Settings limits
   // ----------------------------------------------------------------
   localparam logic [WMG_LW-1:0] WMG_STEP_MASK = 13'h1FFC;
   localparam logic [WMG_LW-1:0] WMG_MIN_WID = 13'h0004;
   localparam logic [WMG_LW:0] WMG_DEPTH = 14'h1000;
   localparam logic [WMG_LW-1:0] WMG_LEN_RST = 13'h1000;
   localparam int WMG_DLY_RES_PS = 10;
   localparam int WMG_DLY_MAX_PS = 3000;
   localparam logic [WMG_DW-1:0] WMG_DLY_MAX = WMG_DW'(WMG_DLY_MAX_PS / WMG_DLY_RES_PS);

   // ----------------------------------------------------------------
   // Register map (byte addresses) and bit positions
   // ----------------------------------------------------------------
   localparam logic [WMG_BUS_AW-1:0] WMG_REG_CTRL = 6'h00;
   localparam logic [WMG_BUS_AW-1:0] WMG_REG_STAT = 6'h04;
   localparam logic [WMG_BUS_AW-1:0] WMG_REG_LEN = 6'h08;
   localparam logic [WMG_BUS_AW-1:0] WMG_REG_MK0 = 6'h0C;
   localparam logic [WMG_BUS_AW-1:0] WMG_MK_STRIDE = 6'h0C;
   localparam logic [WMG_BUS_AW-1:0] WMG_MK_POS = 6'h00;
   localparam logic [WMG_BUS_AW-1:0] WMG_MK_WID = 6'h04;
   localparam logic [WMG_BUS_AW-1:0] WMG_MK_DLY = 6'h08;
   localparam logic [WMG_BUS_AW-1:0] WMG_REG_MADDR = 6'h24;
   localparam logic [WMG_BUS_AW-1:0] WMG_REG_MDATA = 6'h28;
   localparam int WMG_CTRL_RUN = 0;
   localparam int WMG_CTRL_MKEN = 1;
   localparam int WMG_CTRL_APPLY = 2;
   localparam int WMG_STAT_REJ = 0;
   localparam int WMG_STAT_PLAY = 1;
   localparam int WMG_STAT_FULL = 2;

   // Bus access phases
   localparam logic [1:0] WMG_PH_IDLE = 2'h0;
   localparam logic [1:0] WMG_PH_READ = 2'h1;
   localparam logic [1:0] WMG_PH_ACK = 2'h2;

   typedef struct packed {
      logic [WMG_NMK-1:0] mk;
      logic [WMG_SMP_W-1:0] smp;
   } wmg_word_s;

   typedef struct packed {
      logic sof;
      wmg_word_s w;
   } wmg_out_s;

   typedef struct packed {
      logic [WMG_LW-1:0] pos;
      logic [WMG_LW-1:0] wid;
      logic [WMG_DW-1:0] dly;
   } wmg_mk_s;

   localparam wmg_mk_s WMG_MK_RST = '{pos: 13'h0000, wid: WMG_MIN_WID, dly: 9'h000};

   typedef enum logic [1:0] {
      WMG_IDLE = 2'b00,
      WMG_READ = 2'b01,
      WMG_WRITE = 2'b10
   } wmg_st_e;

   function automatic logic [WMG_LW:0] wmg_end(input wmg_mk_s m);
      return {1'b0, m.pos} + {1'b0, m.wid};
   endfunction

   function automatic logic wmg_hit(input logic [WMG_LW-1:0] a, input wmg_mk_s m);
      return (a >= m.pos) && ({1'b0, a} < wmg_end(m));
   endfunction

   function automatic logic [WMG_BUS_AW-1:0] wmg_mk_off(input int i,
                                                        input logic [WMG_BUS_AW-1:0] f);
      return WMG_BUS_AW'(WMG_REG_MK0 + i * WMG_MK_STRIDE + f);
   endfunction

   function automatic logic [WMG_DATA_W-1:0] wmg_be(input logic [WMG_DATA_W-1:0] old,
                                                    input logic [WMG_DATA_W-1:0] nw,
                                                    input logic [WMG_BE_W-1:0] be);
      logic [WMG_DATA_W-1:0] r;
      r = old;
      for (int b = 0; b < WMG_BE_W; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

endpackage

// File: hw/wmg_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; output data is read from the storage flops.
module wmg_fifo #(
   parameter int W = 8,     // Word width
   parameter int DEPTH = 16 // Number of words
) (
   input wire logic clock_i,         // Clock
   input wire logic rst_i,           // Sync reset, active high
   input wire logic in_valid_i,      // Write request
   output logic in_ready_o,          // Room for a word
   input wire logic [W-1:0] in_data_i, // Write word
   output logic out_valid_o,         // Word available
   input wire logic out_ready_i,     // Consumer takes word
   output logic [W-1:0] out_data_o   // Oldest word
);
   localparam int PW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wp_q, rp_q;
   logic [PW:0] cnt_q;

   wire logic push = in_valid_i && in_ready_o;
   wire logic pop = out_valid_o && out_ready_i;

   assign in_ready_o = cnt_q != (PW+1)'(DEPTH);
   assign out_valid_o = cnt_q != '0;
   assign out_data_o = mem[rp_q];

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem[wp_q] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         wp_q <= push ? PW'((wp_q + 1'b1) % DEPTH) : wp_q;
         rp_q <= pop ? PW'((rp_q + 1'b1) % DEPTH) : rp_q;
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // wmg_fifo

// File: hw/wmg_wmem.sv
// Waveform memory: sample word plus marker bits per point, two ports.
// Port A serves bus and apply engine, port B serves playback.
module wmg_wmem
   import wmg_pkg::*;
(
   input wire logic clock_i,                  // Clock
   input wire logic [WMG_AW-1:0] a_addr_i,    // Port A address
   input wire logic a_we_i,                   // Port A write
   input wire wmg_word_s a_wdata_i,           // Port A write word
   output wmg_word_s a_rdata_o,               // Port A read, one cycle late
   input wire logic b_en_i,                   // Port B read enable
   input wire logic [WMG_AW-1:0] b_addr_i,    // Port B address
   output wmg_word_s b_rdata_o                // Port B read, held without enable
);
   wmg_word_s mem [2**WMG_AW];

   always_ff @(posedge clock_i) begin
      if (a_we_i) begin
         mem[a_addr_i] <= a_wdata_i;
      end
      a_rdata_o <= mem[a_addr_i];
   end

   always_ff @(posedge clock_i) begin
      if (b_en_i) begin
         b_rdata_o <= mem[b_addr_i];
      end
   end
endmodule // wmg_wmem

// File: hw/wmg_top.sv
// Marker generator for one waveform channel: register slave, waveform
// memory with marker bits, apply engine and playback into an output FIFO.
// Assumes one 100 MHz clock, synchronous reset and an Avalon-MM master.
module wmg_top
   import wmg_pkg::*;
#(
   parameter int FIFO_DEPTH = WMG_FIFO_D // Output buffer depth
) (
   input wire logic clock_i,                          // 100 MHz clock
   input wire logic rst_i,                            // Sync reset, high
   input wire logic [WMG_BUS_AW-1:0] avs_address_i,   // Byte address
   input wire logic avs_read_i,                       // Read request
   input wire logic avs_write_i,                      // Write request
   input wire logic [WMG_DATA_W-1:0] avs_writedata_i, // Write data
   input wire logic [WMG_BE_W-1:0] avs_byteenable_i,  // Byte lanes
   output logic [WMG_DATA_W-1:0] avs_readdata_o,      // Read data
   output logic avs_waitrequest_o,                    // Stall
   output logic smp_valid_o,                          // Sample valid
   input wire logic smp_ready_i,                      // Sample taken
   output logic [WMG_SMP_W-1:0] smp_data_o,           // Converter word
   output logic [WMG_NMK-1:0] marker_o,               // Marker bits
   output logic wave_start_o,                         // First point
   output logic [WMG_NMK-1:0][WMG_DW-1:0] mk_dly_o    // Fine delay codes
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [1:0] ph_q;
   logic run_q, mk_en_q, apply_q, err_q;
   logic [WMG_LW-1:0] len_q;
   logic [WMG_AW-1:0] maddr_q;
   wmg_mk_s stg_q [WMG_NMK];
   wmg_mk_s act_q [WMG_NMK];
   logic [WMG_DATA_W-1:0] rdata_q;
   wmg_st_e st_q, st_d;
   logic [WMG_LW-1:0] cur_q;
   logic [WMG_LW:0] hi_q;
   logic [WMG_AW-1:0] pb_addr_q;
   logic pb_vld_q, pb_sof_q;

   wmg_word_s a_rdata, b_rdata, a_wdata, eng_word, bus_word;
   wmg_out_s fin_data, fout_data;
   logic fin_rdy, fout_vld;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire logic req = avs_read_i || avs_write_i;
   wire logic eng_idle = st_q == WMG_IDLE;
   // Bus stalls while an apply waits or runs, so port A has one user
   wire logic go = req && ph_q == WMG_PH_IDLE && eng_idle && !apply_q;
   wire logic wr_ok = avs_write_i && ph_q == WMG_PH_ACK;
   wire logic sel_ctrl = avs_address_i == WMG_REG_CTRL;
   wire logic sel_stat = avs_address_i == WMG_REG_STAT;
   wire logic sel_len = avs_address_i == WMG_REG_LEN;
   wire logic sel_maddr = avs_address_i == WMG_REG_MADDR;
   wire logic sel_mdata = avs_address_i == WMG_REG_MDATA;
   wire logic mdata_done = req && ph_q == WMG_PH_ACK && sel_mdata;
   wire logic [WMG_BE_W-1:0] be = avs_byteenable_i;
   wire logic [WMG_DATA_W-1:0] wdat = avs_writedata_i;

   logic [WMG_NMK-1:0] sel_pos, sel_wid, sel_dly;
   logic [WMG_DATA_W-1:0] wd_pos [WMG_NMK];
   logic [WMG_DATA_W-1:0] wd_wid [WMG_NMK];
   logic [WMG_DATA_W-1:0] wd_dly [WMG_NMK];

   for (genvar i = 0; i < WMG_NMK; i++) begin : g_dec
      assign sel_pos[i] = avs_address_i == wmg_mk_off(i, WMG_MK_POS);
      assign sel_wid[i] = avs_address_i == wmg_mk_off(i, WMG_MK_WID);
      assign sel_dly[i] = avs_address_i == wmg_mk_off(i, WMG_MK_DLY);
      assign wd_pos[i] = wmg_be(WMG_DATA_W'(stg_q[i].pos), wdat, be);
      assign wd_wid[i] = wmg_be(WMG_DATA_W'(stg_q[i].wid), wdat, be);
      assign wd_dly[i] = wmg_be(WMG_DATA_W'(stg_q[i].dly), wdat, be);
      assign mk_dly_o[i] = act_q[i].dly;
   end

   wire logic [WMG_DATA_W-1:0] ctrl_rd = WMG_DATA_W'({mk_en_q, run_q});
   wire logic [WMG_DATA_W-1:0] wd_ctrl = wmg_be(ctrl_rd, wdat, be);
   wire logic [WMG_DATA_W-1:0] wd_len = wmg_be(WMG_DATA_W'(len_q), wdat, be);
   wire logic [WMG_DATA_W-1:0] wd_maddr = wmg_be(WMG_DATA_W'(maddr_q), wdat, be);
   wire logic [WMG_DATA_W-1:0] stat_rd =
      WMG_DATA_W'({!fin_rdy, run_q && pb_vld_q, err_q});

   // ----------------------------------------------------------------
   // Read mux; unmapped addresses read zero
   // ----------------------------------------------------------------
   logic [WMG_DATA_W-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      if (sel_ctrl) rd_mux = ctrl_rd;
      if (sel_stat) rd_mux = stat_rd;
      if (sel_len) rd_mux = WMG_DATA_W'(len_q);
      if (sel_maddr) rd_mux = WMG_DATA_W'(maddr_q);
      if (sel_mdata) rd_mux = WMG_DATA_W'(a_rdata);
      for (int i = 0; i < WMG_NMK; i++) begin
         if (sel_pos[i]) rd_mux = WMG_DATA_W'(stg_q[i].pos);
         if (sel_wid[i]) rd_mux = WMG_DATA_W'(stg_q[i].wid);
         if (sel_dly[i]) rd_mux = WMG_DATA_W'(stg_q[i].dly);
      end
   end

   assign avs_waitrequest_o = req && ph_q != WMG_PH_ACK;
   assign avs_readdata_o = rdata_q;

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ph_q <= WMG_PH_IDLE;
         rdata_q <= '0;
      end else begin
         case (ph_q)
            WMG_PH_IDLE: ph_q <= go ? WMG_PH_READ : WMG_PH_IDLE;
            WMG_PH_READ: ph_q <= WMG_PH_ACK;
            default: ph_q <= WMG_PH_IDLE;
         endcase
         if (ph_q == WMG_PH_READ) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control and setting registers
   // ----------------------------------------------------------------
   wire logic start = eng_idle && apply_q && ph_q == WMG_PH_IDLE;
   logic ok_c;

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         run_q <= 1'b0;
         mk_en_q <= 1'b0;
         len_q <= WMG_LEN_RST;
         maddr_q <= '0;
      end else begin
         if (wr_ok && sel_ctrl) begin
            run_q <= wd_ctrl[WMG_CTRL_RUN];
            // R8 one enable for both
            mk_en_q <= wd_ctrl[WMG_CTRL_MKEN];
         end
         if (wr_ok && sel_len) len_q <= wd_len[WMG_LW-1:0];
         if (wr_ok && sel_maddr) begin
            maddr_q <= wd_maddr[WMG_AW-1:0];
         end else if (mdata_done) begin
            maddr_q <= maddr_q + 1'b1;
         end
      end
   end

   // Apply request stays pending until the engine takes it
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         apply_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         if (wr_ok && sel_ctrl && wd_ctrl[WMG_CTRL_APPLY]) begin
            apply_q <= 1'b1;
         end else if (start) begin
            apply_q <= 1'b0;
         end
         if (start) begin
            // R6 bad span refused
            err_q <= !ok_c;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         for (int i = 0; i < WMG_NMK; i++) begin
            stg_q[i] <= WMG_MK_RST;
         end
      end else begin
         for (int i = 0; i < WMG_NMK; i++) begin
            // R3 start in steps of four
            if (wr_ok && sel_pos[i]) stg_q[i].pos <= wd_pos[i][WMG_LW-1:0] & WMG_STEP_MASK;
            // R5 width in steps of four
            if (wr_ok && sel_wid[i]) stg_q[i].wid <= wd_wid[i][WMG_LW-1:0] & WMG_STEP_MASK;
            // R4 delay apart from position
            // R7 delay limited to 3 ns
            if (wr_ok && sel_dly[i]) begin
               stg_q[i].dly <= wd_dly[i] > WMG_DATA_W'(WMG_DLY_MAX) ? WMG_DLY_MAX
                                                                   : wd_dly[i][WMG_DW-1:0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Apply engine: span covering old and new marker regions
   // ----------------------------------------------------------------
   logic [WMG_LW:0] lo_c, hi_c;
   always_comb begin
      lo_c = WMG_DEPTH;
      hi_c = '0;
      ok_c = 1'b1;
      for (int i = 0; i < WMG_NMK; i++) begin
         // R5 minimum width
         // R6 span within waveform
         if (stg_q[i].wid < WMG_MIN_WID || wmg_end(stg_q[i]) > {1'b0, len_q}) ok_c = 1'b0;
         if ({1'b0, act_q[i].pos} < lo_c) lo_c = {1'b0, act_q[i].pos};
         if ({1'b0, stg_q[i].pos} < lo_c) lo_c = {1'b0, stg_q[i].pos};
         if (wmg_end(act_q[i]) > hi_c) hi_c = wmg_end(act_q[i]);
         if (wmg_end(stg_q[i]) > hi_c) hi_c = wmg_end(stg_q[i]);
      end
      if (hi_c > WMG_DEPTH) hi_c = WMG_DEPTH;
   end

   wire logic [WMG_LW:0] cur_nx = {1'b0, cur_q} + (WMG_LW+1)'(1);

   // R12 read, clear, rewrite
   always_comb begin
      st_d = st_q;
      case (st_q)
         WMG_IDLE: begin
            if (start && ok_c && lo_c < hi_c) st_d = WMG_READ;
         end
         WMG_READ: st_d = WMG_WRITE;
         WMG_WRITE: st_d = cur_nx >= hi_q ? WMG_IDLE : WMG_READ;
         default: st_d = WMG_IDLE;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_q <= WMG_IDLE;
         cur_q <= '0;
         hi_q <= '0;
         for (int i = 0; i < WMG_NMK; i++) begin
            act_q[i] <= WMG_MK_RST;
         end
      end else begin
         st_q <= st_d;
         // R11 settings take hold on apply
         if (start && ok_c) begin
            for (int i = 0; i < WMG_NMK; i++) begin
               act_q[i] <= stg_q[i];
            end
            cur_q <= lo_c[WMG_LW-1:0];
            hi_q <= hi_c;
         end else if (st_q == WMG_WRITE) begin
            cur_q <= cur_nx[WMG_LW-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Memory port A: engine when busy, bus otherwise
   // ----------------------------------------------------------------
   wire logic eng_wr = st_q == WMG_WRITE;
   wire logic bus_mwr = wr_ok && sel_mdata;
   wire logic [WMG_DATA_W-1:0] wd_mem = wmg_be(WMG_DATA_W'(a_rdata), wdat, be);

   // R14 samples kept on rewrite
   assign eng_word.smp = a_rdata.smp;
   for (genvar i = 0; i < WMG_NMK; i++) begin : g_pat
      // R9 one pulse from start
      assign eng_word.mk[i] = wmg_hit(cur_q, act_q[i]);
   end

   // R10 arbitrary bits loaded
   assign bus_word = wd_mem[$bits(wmg_word_s)-1:0];
   assign a_wdata = eng_wr ? eng_word : bus_word;

   wire logic pb_issue = run_q && len_q != '0 && (!pb_vld_q || fin_rdy);

   // R2 markers beside samples
   wmg_wmem u_wmem (
      .clock_i(clock_i),
      .a_addr_i(eng_idle ? maddr_q : cur_q[WMG_AW-1:0]),
      .a_we_i(eng_wr || bus_mwr),
      .a_wdata_i(a_wdata),
      .a_rdata_o(a_rdata),
      .b_en_i(pb_issue),
      .b_addr_i(pb_addr_q),
      .b_rdata_o(b_rdata)
   );

   // ----------------------------------------------------------------
   // Playback: one point per cycle, stalled by the output FIFO
   // ----------------------------------------------------------------
   wire logic pb_last = {1'b0, pb_addr_q} + (WMG_LW)'(1) >= len_q;

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pb_addr_q <= '0;
         pb_vld_q <= 1'b0;
         pb_sof_q <= 1'b0;
      end else begin
         if (pb_issue) begin
            pb_addr_q <= pb_last ? '0 : pb_addr_q + 1'b1;
            pb_sof_q <= pb_addr_q == '0;
         end else if (!run_q) begin
            // Restart at the waveform start after every stop
            pb_addr_q <= '0;
         end
         if (pb_issue) begin
            pb_vld_q <= 1'b1;
         end else if (fin_rdy) begin
            pb_vld_q <= 1'b0;
         end
      end
   end

   // R8 gate both markers
   // R1 markers ride with samples
   assign fin_data.sof = pb_sof_q;
   assign fin_data.w.smp = b_rdata.smp;
   assign fin_data.w.mk = b_rdata.mk & {WMG_NMK{mk_en_q}};

   // R13 fixed pipeline depth
   wmg_fifo #(
      .W($bits(wmg_out_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .in_valid_i(pb_vld_q),
      .in_ready_o(fin_rdy),
      .in_data_i(fin_data),
      .out_valid_o(fout_vld),
      .out_ready_i(smp_ready_i),
      .out_data_o(fout_data)
   );

   assign smp_valid_o = fout_vld;
   assign smp_data_o = fout_data.w.smp;
   assign marker_o = fout_data.w.mk;
   assign wave_start_o = fout_data.sof;

endmodule // wmg_top

// File: tb/wmg_monitor.sv
// Port checker bound to wmg_top.
// Assumes the top's ports only, one clock domain.
module wmg_monitor
   import wmg_pkg::*;
(
   input wire logic clock_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic [WMG_BUS_AW-1:0] avs_address_i, // Address
   input wire logic avs_read_i, // Read
   input wire logic avs_write_i, // Write
   input wire logic [WMG_DATA_W-1:0] avs_writedata_i, // Write data
   input wire logic [WMG_BE_W-1:0] avs_byteenable_i, // Lanes
   input wire logic [WMG_DATA_W-1:0] avs_readdata_o, // Read data
   input wire logic avs_waitrequest_o, // Stall
   input wire logic smp_valid_o, // Valid
   input wire logic smp_ready_i, // Ready
   input wire logic [WMG_SMP_W-1:0] smp_data_o, // Sample
   input wire logic [WMG_NMK-1:0] marker_o, // Markers
   input wire logic wave_start_o, // Point 0
   input wire logic [WMG_NMK-1:0][WMG_DW-1:0] mk_dly_o // Delays
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy_q, run_q;
   logic [WMG_LW-1:0] len_q;
   wire req = avs_read_i || avs_write_i;
   wire wr_ack = avs_write_i && !avs_waitrequest_o;
   wire ctrl_wr = wr_ack && avs_address_i == WMG_REG_CTRL && avs_byteenable_i[0];
   // Shadow run and length so the latency check sees a fresh start
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
         run_q <= 1'b0;
         len_q <= WMG_LEN_RST;
      end else begin
         busy_q <= req && avs_waitrequest_o;
         if (ctrl_wr)
            run_q <= avs_writedata_i[WMG_CTRL_RUN];
         if (wr_ack && avs_address_i == WMG_REG_LEN && avs_byteenable_i[1:0] == 2'h3)
            len_q <= avs_writedata_i[WMG_LW-1:0];
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence s_stall2;
      avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   sequence s_first;
      smp_valid_o && wave_start_o;
   endsequence
   chk_idle_no_wait: assert property (!req |-> !avs_waitrequest_o)
      else $error("stall without request");
   chk_req_stall: assert property (req && !busy_q |-> s_stall2)
      else $error("request answered too early");
   chk_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o &&
      avs_address_i > WMG_REG_MDATA |-> avs_readdata_o == '0)
      else $error("unmapped read not zero");
   chk_valid_hold: assert property (smp_valid_o && !smp_ready_i |=> smp_valid_o)
      else $error("valid dropped");
   chk_word_hold: assert property (smp_valid_o && !smp_ready_i |=> $stable(smp_data_o) &&
      $stable(marker_o) && $stable(wave_start_o))
      else $error("word changed while stalled");
   chk_delay_range: assert property (mk_dly_o[0] <= WMG_DLY_MAX && mk_dly_o[1] <= WMG_DLY_MAX)
      else $error("delay code out of range");
   chk_delay_quiet: assert property (wr_ack && avs_address_i != WMG_REG_CTRL |=>
      $stable(mk_dly_o)[*2])
      else $error("delay changed without apply");
   chk_run_latency: assert property (ctrl_wr && avs_writedata_i[0] && !run_q &&
      !avs_writedata_i[2] && !smp_valid_o && len_q != 0 |-> ##[2:3] s_first)
      else $error("start latency wrong");
   chk_start_single: assert property (smp_valid_o && smp_ready_i && wave_start_o &&
      len_q > 1 |=> !(smp_valid_o && wave_start_o))
      else $error("start repeated");
endmodule // wmg_monitor

bind wmg_top wmg_monitor i_wmg_monitor (.clock_i, .rst_i, .avs_address_i, .avs_read_i,
   .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
   .smp_valid_o, .smp_ready_i, .smp_data_o, .marker_o, .wave_start_o, .mk_dly_o);

// File: tb/wmg_sink.sv
// Stream consumer model at the marker generator's output.
// Assumes wmg_top valid/ready; keeps the first 128 words.
module wmg_sink
   import wmg_pkg::*;
(
   input wire logic clock_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic [1:0] mode_i, // 0 take all, 1 slow, 2 halt
   input wire logic smp_valid_i, // Valid
   output logic smp_ready_o, // Ready
   input wire logic [WMG_SMP_W-1:0] smp_data_i, // Sample
   input wire logic [WMG_NMK-1:0] marker_i, // Markers
   input wire logic wave_start_i // Point 0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph_q;
   int cnt;
   wmg_out_s got [128];
   // Slow mode refuses one cycle in four to test the hold
   assign smp_ready_o = mode_i == 2'h0 || (mode_i == 2'h1 && ph_q != 2'h0);
   always @(posedge clock_i) begin
      ph_q <= rst_i ? 2'h0 : ph_q + 2'h1;
      if (rst_i)
         cnt <= 0;
      else if (smp_valid_i && smp_ready_o) begin
         if (cnt < 128)
            got[cnt] <= {wave_start_i, marker_i, smp_data_i};
         cnt <= cnt + 1;
      end
   end
endmodule // wmg_sink

// File: tb/testbench.sv
// Self-checking bench for wmg_top over Avalon-MM.
// Assumes wmg_monitor is bound and wmg_sink takes the stream.
module testbench
   import wmg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [5:0] ad = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata;
   logic wt, sv, sr, st;
   logic [15:0] sd;
   logic [1:0] mk;
   logic [1:0] mode = 2'h0;
   logic [1:0][8:0] dly;
   int errors = 0;
   int checks_done = 0;
   wmg_top i_wmg_top (.clock_i(clock_i), .rst_i(rst_i), .avs_address_i(ad), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wt), .smp_valid_o(sv), .smp_ready_i(sr), .smp_data_o(sd),
      .marker_o(mk), .wave_start_o(st), .mk_dly_o(dly));
   wmg_sink i_wmg_sink (.clock_i(clock_i), .rst_i(rst_i), .mode_i(mode), .smp_valid_i(sv),
      .smp_ready_o(sr), .smp_data_i(sd), .marker_i(mk), .wave_start_i(st));
   initial forever #5 clock_i = ~clock_i;
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_ack();
      do @(posedge clock_i);
      while (wt !== 1'b0);
   endtask
   task automatic wr32(input logic [5:0] a, input logic [31:0] d);
      ad <= a;
      wd <= d;
      wr <= 1'b1;
      wait_ack();
      wr <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      ad <= a;
      rd <= 1'b1;
      wait_ack();
      check(rdata, e);
      rd <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic wait_cnt(input int c);
      while (i_wmg_sink.cnt < c)
         @(posedge clock_i);
   endtask
   // Marker bits per point; points 1..3 hold a loaded string
   function automatic logic [1:0] emk(input int i, input bit rem);
      if (rem && i >= 1 && i < 4)
         return 2'(i);
      return {i >= 8 && i < 12, i >= 4 && i < 12};
   endfunction
   initial begin
      #500us;
      errors++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      for (int m = 0; m < 2; m++) begin
         rdc(6'(8'h0C + 12 * m), 32'h0);
         rdc(6'(8'h10 + 12 * m), 32'h4);
         rdc(6'(8'h14 + 12 * m), 32'h0);
      end
      rdc(WMG_REG_LEN, 32'h1000);
      wr32(6'h3C, 32'hFFFFFFFF);
      rdc(6'h3C, 32'h0);
      wr32(WMG_REG_LEN, 32'h10);
      wr32(WMG_REG_MADDR, 32'h0);
      for (int i = 0; i < 16; i++)
         wr32(WMG_REG_MDATA, 32'h100 + i);
      wr32(6'h0C, 32'h6);
      wr32(6'h10, 32'hA);
      wr32(6'h14, 32'h1FF);
      wr32(6'h18, 32'h8);
      wr32(6'h1C, 32'h4);
      wr32(6'h20, 32'h5);
      rdc(6'h0C, 32'h4);
      rdc(6'h10, 32'h8);
      rdc(6'h14, 32'd300);
      check(dly[0], 32'h0);
      wr32(WMG_REG_CTRL, 32'h4);
      rdc(WMG_REG_STAT, 32'h0);
      check(dly[0], 32'd300);
      check(dly[1], 32'h5);
      wr32(WMG_REG_MADDR, 32'h0);
      for (int i = 0; i < 16; i++)
         rdc(WMG_REG_MDATA, {14'h0, emk(i, 0), 16'(32'h100 + i)});
      wr32(6'h18, 32'hC);
      wr32(6'h1C, 32'h8);
      wr32(WMG_REG_CTRL, 32'h4);
      rdc(WMG_REG_STAT, 32'h1);
      check(dly[1], 32'h5);
      wr32(WMG_REG_MADDR, 32'h1);
      for (int i = 1; i < 4; i++)
         wr32(WMG_REG_MDATA, {14'h0, 2'(i), 16'(32'h100 + i)});
      mode <= 2'h1;
      wr32(WMG_REG_CTRL, 32'h3);
      wait_cnt(20);
      for (int k = 0; k < 20; k++)
         check(32'(i_wmg_sink.got[k]), {13'h0, k % 16 == 0, emk(k % 16, 1),
            16'(32'h100 + k % 16)});
      wr32(WMG_REG_CTRL, 32'h1);
      wait_cnt(i_wmg_sink.cnt + 40);
      for (int k = 1; k <= 16; k++)
         check(i_wmg_sink.got[i_wmg_sink.cnt - k].w.mk, 32'h0);
      mode <= 2'h2;
      repeat (40) @(posedge clock_i);
      rdc(WMG_REG_STAT, 32'h7);
      mode <= 2'h0;
      wr32(WMG_REG_CTRL, 32'h0);
      repeat (40) @(posedge clock_i);
      check(sv, 32'h0);
      test_done();
   end
endmodule // testbench
